// ### logic/rpwu_pkg.sv
// Shared constants and types of the port-write unit
package rpwu_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W         = 17;
  localparam logic [16:0] OFF_IRQ_STATUS = 17'h10080;
  localparam logic [16:0] OFF_IRQ_ENABLE = 17'h10084;
  localparam logic [16:0] OFF_TX_CTRL    = 17'h10200;
  localparam logic [16:0] OFF_TX_BUF     = 17'h10210;
  localparam logic [16:0] OFF_TX_BUF_END = 17'h1024c;
  localparam logic [16:0] OFF_RX_CTRL    = 17'h10250;
  localparam logic [16:0] OFF_RX_STATUS  = 17'h10254;
  localparam logic [16:0] OFF_RX_BUF     = 17'h10260;
  localparam logic [16:0] OFF_RX_BUF_END = 17'h1029c;

  // ****************************************
  // Fields and sizes
  // ****************************************
  localparam int          PAYLOAD_WORDS  = 16;
  localparam logic [6:0]  PAYLOAD_BYTES  = 7'h40;
  localparam int          IRQ_W          = 5;
  localparam int          IRQ_TX_SENT    = 0;
  localparam int          IRQ_RX_DROP    = 1;
  localparam int          IRQ_RX_STORED  = 4;
  localparam int          TX_READY_BIT   = 0;
  localparam int          TX_SIZE_LSB    = 4;
  localparam int          TX_DEST_LSB    = 16;
  localparam int          RX_EN_BIT      = 0;

  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [4:0]  IRQ_MASK_RST   = 5'h00;
  localparam logic [15:0] TX_DEST_RST    = 16'h0000;
  localparam logic [6:0]  TX_SIZE_RST    = 7'h00;
  localparam logic [6:0]  RX_SIZE_RST    = 7'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ****************************************
  // Link beats and states
  // ****************************************
  typedef struct packed {
    logic [15:0] dest_id;
    logic [31:0] data;
    logic        last;
  } rpwu_tx_beat_t;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } rpwu_rx_beat_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b11
  } rpwu_tx_state_t;

endpackage

// ### logic/rpwu_ram.sv
// Small payload memory with registered read data
module rpwu_ram #(
  parameter int DW    = 32,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ### logic/rpwu_irq.sv
// Sticky interrupt status with mask and level output
module rpwu_irq #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Events and software access
  input  wire logic [W-1:0] set_ev,
  input  wire logic [W-1:0] clr_w1c,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_wdata,
  // State
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq_out
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_w1c) | set_ev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask <= rpwu_pkg::IRQ_MASK_RST;
    end else if (mask_we) begin
      mask <= mask_wdata;
    end
  end

  assign irq_out = |(status & mask);

endmodule

// ### logic/rpwu_core.sv
// Port-write unit: AXI4-Lite registers, outbound sender, inbound store
// ****************************************
// Summary of operation
// RQ1 - Interrupt output high while any enabled maintenance or I/O flag is set.
// RQ2 - Writing 0x10 to the enable register unmasks the stored-packet interrupt.
// RQ3 - Inbound port writes are stored only while receive enable is set.
// RQ4 - Outbound payload is sixteen words written at 0x10210 to 0x1024C.
// RQ5 - Writing destination plus ready bit to 0x10200 sends the payload.
// RQ6 - A stored inbound port write sets the packet-stored flag.
// RQ7 - Inbound payload reads back as words at 0x10260 to 0x1029C.
// RQ8 - Receive status reports the byte size of the latest stored packet.
// RQ9 - Writing one to status bit 4 clears it, arming the next packet.
// RQ10 - Payloads are at most 64 bytes in both directions.
// RQ11 - Interrupt drops once no enabled flag remains set.
// ****************************************
//
// The AXI4-Lite interface to the registers was decided locally.
module rpwu_core (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // AXI4-Lite write
  input  wire logic [16:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [16:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Outbound link
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output rpwu_pkg::rpwu_tx_beat_t     tx_beat,
  // Inbound link
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  input  wire rpwu_pkg::rpwu_rx_beat_t rx_beat,
  // Interrupts
  input  wire logic                   io_irq_pending,
  output logic                        maint_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                     aw_held_r, w_held_r, bvalid_r;
  logic [16:0]              aw_addr_r, ar_addr_r, tx_woff, rx_roff, tx_roff;
  logic [31:0]              w_data_r, rdata_r;
  logic [3:0]               w_strb_r;
  logic [1:0]               bresp_r, rresp_r;
  logic                     rd_ph1_r, rd_ph2_r, rvalid_r;
  logic                     wr_go, wr_hit, in_tx_w, in_rx_r, in_tx_r;
  logic [31:0]              wr_mask, wr_merged, ctrl_word, tx_rdata, rx_rdata;
  rpwu_pkg::rpwu_tx_state_t tx_state_r;
  logic [3:0]               tx_idx_r, tx_last_r, tx_raddr;
  logic [15:0]              tx_dest_r;
  logic [6:0]               tx_size_r, rx_size_r;
  logic                     tx_start, tx_sent_ev, irq_mask_we, irq_core;
  logic                     rx_en_r, rx_in_pkt_r, rx_take_r, rx_take_now;
  logic [4:0]               rx_cnt_r, rx_cnt_nxt;
  logic                     rx_beat_ok, rx_we, rx_stored_ev, rx_drop_ev;
  logic [4:0]               irq_set, irq_clr, irq_status, irq_mask;

  function automatic logic [3:0] last_idx(input logic [6:0] sz);
    logic [6:0] words;
    words = (sz + 7'h03) >> 2;
    if (sz == 7'h00 || sz > rpwu_pkg::PAYLOAD_BYTES) begin
      words = 7'h10;
    end
    return 4'(words - 7'h01);
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bresp_r   <= rpwu_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? rpwu_pkg::RESP_OKAY : rpwu_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign ctrl_word = {tx_dest_r, 5'h00, tx_size_r, 3'h0, tx_state_r != rpwu_pkg::TX_IDLE};
  assign in_tx_w = aw_addr_r >= rpwu_pkg::OFF_TX_BUF && aw_addr_r <= rpwu_pkg::OFF_TX_BUF_END;
  assign tx_woff = aw_addr_r - rpwu_pkg::OFF_TX_BUF;
  assign wr_merged = (ctrl_word & ~wr_mask) | (w_data_r & wr_mask);
  assign wr_hit = in_tx_w || aw_addr_r inside {rpwu_pkg::OFF_IRQ_STATUS,
                  rpwu_pkg::OFF_IRQ_ENABLE, rpwu_pkg::OFF_TX_CTRL, rpwu_pkg::OFF_RX_CTRL,
                  rpwu_pkg::OFF_RX_STATUS, [rpwu_pkg::OFF_RX_BUF:rpwu_pkg::OFF_RX_BUF_END]};

  // Only the low byte holds interrupt bits
  assign irq_clr = (wr_go && aw_addr_r == rpwu_pkg::OFF_IRQ_STATUS && w_strb_r[0]) ?
                   w_data_r[4:0] : 5'h00; // RQ9
  assign irq_mask_we = wr_go && aw_addr_r == rpwu_pkg::OFF_IRQ_ENABLE && w_strb_r[0]; // RQ2

  // Ready bit while busy is ignored: the sender owns dest and size then
  assign tx_start = wr_go && aw_addr_r == rpwu_pkg::OFF_TX_CTRL &&
                    tx_state_r == rpwu_pkg::TX_IDLE &&
                    wr_merged[rpwu_pkg::TX_READY_BIT]; // RQ5

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_dest_r <= rpwu_pkg::TX_DEST_RST;
      tx_size_r <= rpwu_pkg::TX_SIZE_RST;
    end else if (wr_go && aw_addr_r == rpwu_pkg::OFF_TX_CTRL &&
                 tx_state_r == rpwu_pkg::TX_IDLE) begin
      tx_dest_r <= wr_merged[rpwu_pkg::TX_DEST_LSB +: 16];
      tx_size_r <= wr_merged[rpwu_pkg::TX_SIZE_LSB +: 7];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_en_r <= 1'b0;
    end else if (wr_go && aw_addr_r == rpwu_pkg::OFF_RX_CTRL && w_strb_r[0]) begin
      rx_en_r <= w_data_r[rpwu_pkg::RX_EN_BIT]; // RQ3
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !rd_ph1_r && !rd_ph2_r && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign in_tx_r = ar_addr_r >= rpwu_pkg::OFF_TX_BUF && ar_addr_r <= rpwu_pkg::OFF_TX_BUF_END;
  assign in_rx_r = ar_addr_r >= rpwu_pkg::OFF_RX_BUF && ar_addr_r <= rpwu_pkg::OFF_RX_BUF_END;
  assign tx_roff = ar_addr_r - rpwu_pkg::OFF_TX_BUF;
  assign rx_roff = ar_addr_r - rpwu_pkg::OFF_RX_BUF;

  // Phase one presents the memory address, phase two has its data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_ph1_r  <= 1'b0;
      rd_ph2_r  <= 1'b0;
      rvalid_r  <= 1'b0;
      ar_addr_r <= '0;
      rdata_r   <= '0;
      rresp_r   <= rpwu_pkg::RESP_OKAY;
    end else begin
      rd_ph1_r <= s_axi_arvalid && s_axi_arready;
      rd_ph2_r <= rd_ph1_r;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r <= s_axi_araddr;
      end
      if (rd_ph2_r) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rpwu_pkg::RESP_OKAY;
        case (ar_addr_r)
          rpwu_pkg::OFF_IRQ_STATUS: rdata_r <= {27'h0, irq_status};
          rpwu_pkg::OFF_IRQ_ENABLE: rdata_r <= {27'h0, irq_mask};
          rpwu_pkg::OFF_TX_CTRL:    rdata_r <= ctrl_word;
          rpwu_pkg::OFF_RX_CTRL:    rdata_r <= {31'h0, rx_en_r};
          rpwu_pkg::OFF_RX_STATUS:  rdata_r <= {25'h0, rx_size_r}; // RQ8
          default: begin
            if (in_tx_r) begin
              rdata_r <= tx_rdata; // RQ4
            end else if (in_rx_r) begin
              rdata_r <= rx_rdata; // RQ7
            end else begin
              rdata_r <= '0;
              rresp_r <= rpwu_pkg::RESP_SLVERR;
            end
          end
        endcase
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outbound sender
  // ****************************************
  // Sender has the read port while busy; reads of the buffer then see its word
  assign tx_raddr = (tx_state_r != rpwu_pkg::TX_IDLE) ? tx_idx_r : tx_roff[5:2];

  rpwu_ram #(.DW(32), .DEPTH(rpwu_pkg::PAYLOAD_WORDS)) u_tx_ram (
    .ref_clk (ref_clk),
    .reset   (reset),
    .we      (wr_go && in_tx_w), // RQ4
    .waddr   (tx_woff[5:2]),
    .wdata   ((w_data_r & wr_mask)),
    .raddr   (tx_raddr),
    .rdata   (tx_rdata)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_state_r <= rpwu_pkg::TX_IDLE;
      tx_idx_r   <= 4'h0;
      tx_last_r  <= 4'h0;
    end else begin
      case (tx_state_r)
        rpwu_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state_r <= rpwu_pkg::TX_LOAD;
            tx_idx_r   <= 4'h0;
            tx_last_r  <= last_idx(wr_merged[rpwu_pkg::TX_SIZE_LSB +: 7]); // RQ10
          end
        end
        rpwu_pkg::TX_LOAD: tx_state_r <= rpwu_pkg::TX_SEND;
        rpwu_pkg::TX_SEND: begin
          if (tx_ready) begin
            tx_idx_r   <= tx_idx_r + 4'h1;
            tx_state_r <= (tx_idx_r == tx_last_r) ? rpwu_pkg::TX_IDLE : rpwu_pkg::TX_LOAD;
          end
        end
        default: tx_state_r <= rpwu_pkg::TX_IDLE;
      endcase
    end
  end

  assign tx_valid        = tx_state_r == rpwu_pkg::TX_SEND;
  assign tx_beat.dest_id = tx_dest_r; // RQ5
  assign tx_beat.data    = tx_rdata;
  assign tx_beat.last    = tx_idx_r == tx_last_r;
  assign tx_sent_ev      = tx_valid && tx_ready && tx_beat.last;

  // ****************************************
  // Inbound store
  // ****************************************
  // Always drains the link; a packet not taken is discarded
  assign rx_ready    = !reset;
  assign rx_beat_ok  = rx_valid && rx_ready;
  assign rx_take_now = rx_in_pkt_r ? rx_take_r
                                   : (rx_en_r && !irq_status[rpwu_pkg::IRQ_RX_STORED]); // RQ3
  assign rx_cnt_nxt  = (rx_cnt_r < 5'h10) ? rx_cnt_r + 5'h01 : rx_cnt_r;
  assign rx_we       = rx_beat_ok && rx_take_now && rx_cnt_r < 5'h10; // RQ10
  assign rx_stored_ev = rx_beat_ok && rx_beat.last && rx_take_now; // RQ6
  assign rx_drop_ev  = rx_beat_ok && !rx_in_pkt_r && rx_en_r &&
                       irq_status[rpwu_pkg::IRQ_RX_STORED];

  rpwu_ram #(.DW(32), .DEPTH(rpwu_pkg::PAYLOAD_WORDS)) u_rx_ram (
    .ref_clk (ref_clk),
    .reset   (reset),
    .we      (rx_we),
    .waddr   (rx_cnt_r[3:0]),
    .wdata   (rx_beat.data),
    .raddr   (rx_roff[5:2]), // RQ7
    .rdata   (rx_rdata)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_in_pkt_r <= 1'b0;
      rx_take_r   <= 1'b0;
      rx_cnt_r    <= 5'h00;
      rx_size_r   <= rpwu_pkg::RX_SIZE_RST;
    end else if (rx_beat_ok) begin
      if (rx_beat.last) begin
        rx_in_pkt_r <= 1'b0;
        rx_cnt_r    <= 5'h00;
        if (rx_take_now) begin
          rx_size_r <= {rx_cnt_nxt, 2'b00}; // RQ8
        end
      end else begin
        rx_in_pkt_r <= 1'b1;
        rx_take_r   <= rx_take_now;
        rx_cnt_r    <= rx_cnt_nxt;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_set = {rx_stored_ev, 2'b00, rx_drop_ev, tx_sent_ev}; // RQ6

  rpwu_irq #(.W(rpwu_pkg::IRQ_W)) u_irq (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .set_ev     (irq_set),
    .clr_w1c    (irq_clr),
    .mask_we    (irq_mask_we),
    .mask_wdata (w_data_r[4:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq_out    (irq_core)
  );

  assign maint_irq = irq_core || io_irq_pending; // RQ1 RQ11

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_irq_level_or: assert property ((io_irq_pending |-> maint_irq) and // RQ1
    ((rx_stored_ev && irq_mask[4] && !irq_mask_we) |=> maint_irq))
    else $error("interrupt output low while an enabled flag is set");
  a_irq_release_clear: assert property (($fell(irq_status[4]) && (irq_status & irq_mask) == 5'h00
    && !io_irq_pending) |-> !maint_irq) // RQ11
    else $error("interrupt stays high after last flag cleared");
  a_mask_write_value: assert property ((irq_mask_we && w_data_r[7:0] == 8'h10)
    |=> irq_mask == 5'h10) // RQ2
    else $error("enable write of 0x10 not applied");
  a_rx_enable_gate: assert property ((rx_valid && !rx_in_pkt_r && !rx_en_r) |-> !rx_take_now
    ##1 !$rose(irq_status[4])) // RQ3
    else $error("packet taken while receive disabled");
  a_tx_start_send: assert property (tx_start |=> tx_state_r == rpwu_pkg::TX_LOAD ##1 tx_valid
    && tx_idx_r == 4'h0) // RQ5
    else $error("ready trigger did not start send");
  a_tx_dest_held: assert property ((tx_valid && !tx_ready) |=> tx_valid && $stable(tx_beat)) // RQ5
    else $error("outbound beat changed while stalled");
  a_tx_last_bound: assert property ((tx_valid && tx_beat.last) |-> // RQ10
    ((tx_size_r == 7'h00 || tx_size_r > rpwu_pkg::PAYLOAD_BYTES) ? tx_idx_r == 4'hf :
     ({1'b0, tx_idx_r, 2'b00} < tx_size_r && {1'b0, tx_idx_r, 2'b00} + 7'h04 >= tx_size_r)))
    else $error("outbound packet length wrong");
  a_rx_store_flag: assert property (rx_stored_ev |=> irq_status[4]
    && rx_size_r <= 7'h40 && rx_size_r != 7'h00) // RQ6
    else $error("stored packet not flagged or size wrong");
  a_w1c_clear_bit: assert property ((irq_clr[4] && !rx_stored_ev) |=> !irq_status[4]) // RQ9
    else $error("write one did not clear packet-stored flag");
  a_rd_latency_fixed: assert property ((s_axi_arvalid && s_axi_arready) |-> ##3 s_axi_rvalid) // RQ7
    else $error("read answer not three cycles after address");

  c_tx_packet_done: cover property (tx_sent_ev && tx_idx_r == 4'hf);
  c_rx_packet_stored: cover property (rx_stored_ev ##[1:40] maint_irq);
  c_rx_packet_drop: cover property (rx_drop_ev);
  c_irq_clear_rearm: cover property ($fell(irq_status[4]) ##[1:100] rx_stored_ev);

endmodule

// ### dv/rpwu_link_peer.sv
// Far-side endpoint model of the port-write link
module rpwu_link_peer (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // Outbound beats from the unit
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire rpwu_pkg::rpwu_tx_beat_t tx_beat,
  // Inbound beats to the unit
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  output rpwu_pkg::rpwu_rx_beat_t      rx_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                    stall;
  rpwu_pkg::rpwu_tx_beat_t got_q[$];

  initial begin
    stall = 1'b0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_beat = '0;
  end

  // Slow mode refuses every other cycle, so stalled beats must hold
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_beat);
    tx_ready <= reset ? 1'b0 : (stall ? ~tx_ready : 1'b1);
  end

  // Packets are capped at sixteen words
  task automatic send(input logic [31:0] base, input int n);
    for (int i = 0; i < n && i < 16; i++) begin
      rx_valid <= 1'b1;
      rx_beat <= {32'(base + i), i == n - 1 || i == 15};
      @(posedge ref_clk);
      while (!rx_ready) @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    // Released data lines do not keep the last word
    rx_beat <= ~rx_beat;
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench of the port-write unit
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic                    ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic                    awready, wready, bvalid, arready, rvalid, io_irq, irq;
  logic                    tx_valid, tx_ready, rx_valid, rx_ready;
  logic [16:0]             awaddr, araddr;
  logic [31:0]             wdata, rdata;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp;
  rpwu_pkg::rpwu_tx_beat_t tx_beat;
  rpwu_pkg::rpwu_rx_beat_t rx_beat;
  int                      failures, compares;

  rpwu_core rpwu_core_inst (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
    .io_irq_pending(io_irq), .maint_irq(irq));
  rpwu_link_peer rpwu_link_peer_inst (.ref_clk(ref_clk), .reset(reset),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [16:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic rd(input logic [16:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(rpwu_pkg::OFF_IRQ_STATUS, 32'h0, 2'b00);
    rd(rpwu_pkg::OFF_IRQ_ENABLE, 32'h0, 2'b00);
    rd(rpwu_pkg::OFF_TX_CTRL, 32'h0, 2'b00);
    rd(rpwu_pkg::OFF_RX_CTRL, 32'h0, 2'b00);
    wr(rpwu_pkg::OFF_RX_STATUS, 32'h5, 2'b00);
    rd(rpwu_pkg::OFF_RX_STATUS, 32'h0, 2'b00);
    wr(17'h00100, 32'h1, rpwu_pkg::RESP_SLVERR);
    rd(17'h00100, 32'h0, rpwu_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_tx();
    logic [6:0] sz;
    int         nw;
    for (int k = 0; k < 2; k++) begin
      sz = k ? 7'h08 : 7'h40;
      nw = k ? 2 : 16;
      rpwu_link_peer_inst.stall <= (k == 0);
      rpwu_link_peer_inst.got_q.delete();
      for (int i = 0; i < 16; i++)
        wr(rpwu_pkg::OFF_TX_BUF + 17'(4 * i), 32'h5a000000 + 32'(k * 256 + i), 2'b00);
      wr(rpwu_pkg::OFF_TX_CTRL, {16'h0055, 5'h00, sz, 3'h0, 1'b1}, 2'b00);
      for (int n = 0; n < 500 && rpwu_link_peer_inst.got_q.size() < nw; n++)
        @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      `CHK(rpwu_link_peer_inst.got_q.size(), nw)
      for (int i = 0; i < nw; i++)
        `CHK(rpwu_link_peer_inst.got_q[i], {16'h0055, 32'h5a000000 + 32'(k * 256 + i), i == nw - 1})
      rd(rpwu_pkg::OFF_IRQ_STATUS, 32'h1, 2'b00);
      `CHK(irq, 1'b0)
      wr(rpwu_pkg::OFF_IRQ_STATUS, 32'h1, 2'b00);
    end
    $display("test tx done");
  endtask

  task automatic t_rx();
    rpwu_link_peer_inst.send(32'h1000, 2);
    rd(rpwu_pkg::OFF_IRQ_STATUS, 32'h0, 2'b00);
    wr(rpwu_pkg::OFF_IRQ_ENABLE, 32'h10, 2'b00);
    wr(rpwu_pkg::OFF_RX_CTRL, 32'h1, 2'b00);
    rpwu_link_peer_inst.send(32'h2000, 2);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rd(rpwu_pkg::OFF_IRQ_STATUS, 32'h10, 2'b00);
    rd(rpwu_pkg::OFF_RX_BUF, 32'h2000, 2'b00);
    rd(rpwu_pkg::OFF_RX_BUF + 17'h4, 32'h2001, 2'b00);
    rd(rpwu_pkg::OFF_RX_STATUS, 32'h8, 2'b00);
    // Flag still set, so this packet must not overwrite the stored one
    rpwu_link_peer_inst.send(32'h3000, 1);
    rd(rpwu_pkg::OFF_RX_BUF, 32'h2000, 2'b00);
    rd(rpwu_pkg::OFF_IRQ_STATUS, 32'h12, 2'b00);
    wr(rpwu_pkg::OFF_IRQ_STATUS, 32'h12, 2'b00);
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    rpwu_link_peer_inst.send(32'h4000, 16);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rd(rpwu_pkg::OFF_RX_STATUS, 32'h40, 2'b00);
    rd(rpwu_pkg::OFF_RX_BUF_END, 32'h400f, 2'b00);
    wr(rpwu_pkg::OFF_IRQ_STATUS, 32'h10, 2'b00);
    io_irq <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    io_irq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    $display("test rx done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Clock, reset, sequence, watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready, io_irq} = 7'h40;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    summarize();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
